// ### shared/swc_pkg.sv
// package of constants and types for the standby and wake controller
`default_nettype none

package swc_pkg;

    // ********************
    // register offsets (byte addresses on the register bus)
    // ********************
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;

    // ********************
    // control register fields and reset values
    // ********************
    localparam int CTRL_WAKE_A = 0;
    localparam int CTRL_WAKE_B = 1;
    localparam int CTRL_PD_A = 2;
    localparam int CTRL_PD_B = 3;
    localparam int CTRL_DET_A = 4;
    localparam logic [4:0] CTRL_RESET = 5'h1C;

    // ********************
    // status register fields
    // ********************
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SYS_RESET = 2;
    localparam int ST_FETCH = 3;
    localparam int ST_OSC_RUN = 4;
    localparam int ST_PERM_A = 5;
    localparam int ST_PERM_B = 6;

    // ********************
    // interrupt status and mask fields
    // ********************
    localparam int IRQ_W = 4;
    localparam int IRQ_HALT_WAKE = 0;
    localparam int IRQ_HOLD_WAKE = 1;
    localparam int IRQ_REL_REQ = 2;
    localparam int IRQ_SYS_RST = 3;
    localparam logic [3:0] IRQ_STAT_RESET = 4'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // ********************
    // timing
    // ********************
    localparam int CORE_HZ = 100000000;
    localparam int CLK_NS = 10;
    localparam int OSC_HZ = 455000;
    localparam int OSC_PER_INSTR = 8;
    localparam int INSTR_NS = 17600;
    localparam int RST_HOLD_CYCLES = (INSTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRT_MS = 108;
    localparam int FRT_TICKS = FRT_MS * OSC_HZ / 1000;
    localparam int WDT_TICKS = 32768;
    localparam int ACC_W = 28;
    localparam int CNT_W = 16;
    localparam int HOLD_W = 12;

    // ********************
    // operating states
    // ********************
    typedef enum logic [1:0] {
        SWC_RESET,
        SWC_RUN,
        SWC_HALT,
        SWC_HOLD
    } swc_mode_t;

endpackage

`default_nettype wire

// ### logic/swc_osc_tick.sv
// resonator oscillator model: one tick per oscillator period, stoppable
`default_nettype none

module swc_osc_tick #(
    parameter int OSC_HZ = swc_pkg::OSC_HZ,
    parameter int CORE_HZ = swc_pkg::CORE_HZ
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // control
    input wire logic run,
    // result
    output logic tick
);

    typedef struct packed {
        logic [swc_pkg::ACC_W-1:0] acc;
        logic tick;
    } swc_tick_t;

    localparam logic [swc_pkg::ACC_W-1:0] INC = swc_pkg::ACC_W'(OSC_HZ);
    localparam logic [swc_pkg::ACC_W-1:0] MOD = swc_pkg::ACC_W'(CORE_HZ);

    swc_tick_t cur;
    swc_tick_t next_cur;
    logic [swc_pkg::ACC_W-1:0] sum;

    // phase accumulator, frozen while the oscillator is stopped
    always_comb begin
        next_cur = cur;
        sum = cur.acc + INC;
        next_cur.tick = 1'b0;
        if (run) begin
            if (sum >= MOD) begin
                next_cur.acc = sum - MOD;
                next_cur.tick = 1'b1;
            end else begin
                next_cur.acc = sum;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign tick = cur.tick;

endmodule

`default_nettype wire

// ### logic/standby_wake_control.sv
// standby and wake controller: suspend, oscillator stop, wake and reset sources
// Overview of operation
// [RULE1] suspend stops instruction fetch; oscillator keeps running
// [RULE2] suspend ends on system reset or the release request
// [RULE3] free-running timer raises the release request every 108 ms
// [RULE4] oscillator stop halts oscillator, timers and all oscillator-clocked logic
// [RULE5] oscillator stop ends on system reset or a high key input
// [RULE6] a key group wakes only if its permission was set before entry
// [RULE7] oscillator stop instruction disables the resonator drive output
// [RULE8] with the option built in, all four group-A keys high resets
// [RULE9] reset turns on key pull-downs and group-A simultaneous-high detection
// [RULE10] clocks derive from the 455 kHz oscillator; instruction cycle 17.6 us
// [RULE11] optional watchdog; its expiry is one more reset source
// [RULE12] reset pin pulled up inside; outside circuit drives it low
// [RULE13] non-reset wake resumes at the next instruction, state kept
// [RULE14] all reset sources merge into one synchronized reset, one instruction long
`default_nettype none

module standby_wake_control #(
    parameter bit SIMUL_RESET_EN = 1'b1,
    parameter bit WATCHDOG_EN = 1'b1,
    parameter logic [15:0] FRT_PERIOD = 16'(swc_pkg::FRT_TICKS),
    parameter logic [15:0] WDT_PERIOD = 16'(swc_pkg::WDT_TICKS),
    parameter int ADDR_W = 12
) (
    // clock, reset, clock enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor core side
    input wire logic haltReq,
    input wire logic holdReq,
    input wire logic wdtKick,
    output logic fetchEnable,
    output logic instrTick,
    output logic sysReset,
    output logic wakeResume,
    // pins
    input wire logic resetInputPin_n,
    input wire logic [3:0] keyGroupA,
    input wire logic [3:0] keyGroupB,
    output logic oscOutPinEnable,
    output logic pullDownA,
    output logic pullDownB,
    // interrupt
    output logic irq
);

    // ********************
    // state
    // ********************
    typedef struct packed {
        swc_pkg::swc_mode_t mode;
        logic syncRst1;
        logic syncRst2;
        logic [swc_pkg::HOLD_W-1:0] holdCnt;
        logic [2:0] instrDiv;
        logic instrTick;
        logic [swc_pkg::CNT_W-1:0] frtCnt;
        logic relReq;
        logic [swc_pkg::CNT_W-1:0] wdtCnt;
        logic permA;
        logic permB;
        logic [4:0] ctrl;
        logic [swc_pkg::IRQ_W-1:0] irqStat;
        logic [swc_pkg::IRQ_W-1:0] irqMask;
        logic [31:0] prdata;
        logic fetchEn;
        logic oscOutEn;
        logic sysReset;
        logic wakePulse;
    } swc_state_t;

    localparam logic [swc_pkg::HOLD_W-1:0] HOLD_LAST = swc_pkg::HOLD_W'(swc_pkg::RST_HOLD_CYCLES - 1);
    localparam logic [2:0] INSTR_LAST = 3'(swc_pkg::OSC_PER_INSTR - 1);

    swc_state_t cur;
    swc_state_t next_cur;
    logic oscTick;
    logic oscRun;
    logic simulHigh;
    logic wdtExpire;
    logic rstSource;
    logic keyWake;
    logic apbWrite;
    logic apbSetup;
    logic [swc_pkg::IRQ_W-1:0] irqSet;
    logic [swc_pkg::IRQ_W-1:0] irqClr;

    // ********************
    // register decode helpers
    // ********************
    function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        regHit = (12'(a) == ofs);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = regHit(a, swc_pkg::OFS_CTRL) || regHit(a, swc_pkg::OFS_STATUS) ||
                 regHit(a, swc_pkg::OFS_IRQ_STAT) || regHit(a, swc_pkg::OFS_IRQ_MASK);
    endfunction

    function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a, input swc_state_t s);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (regHit(a, swc_pkg::OFS_CTRL)) begin
            d[4:0] = s.ctrl;
        end else if (regHit(a, swc_pkg::OFS_STATUS)) begin
            d[swc_pkg::ST_STATE_LSB +: 2] = s.mode;
            d[swc_pkg::ST_SYS_RESET] = s.sysReset;
            d[swc_pkg::ST_FETCH] = s.fetchEn;
            d[swc_pkg::ST_OSC_RUN] = s.oscOutEn;
            d[swc_pkg::ST_PERM_A] = s.permA;
            d[swc_pkg::ST_PERM_B] = s.permB;
        end else if (regHit(a, swc_pkg::OFS_IRQ_STAT)) begin
            d[swc_pkg::IRQ_W-1:0] = s.irqStat;
        end else if (regHit(a, swc_pkg::OFS_IRQ_MASK)) begin
            d[swc_pkg::IRQ_W-1:0] = s.irqMask;
        end
        readMux = d;
    endfunction

    // ********************
    // oscillator
    // ********************

    // oscillator runs in every mode except oscillator stop
    assign oscRun = cur.oscOutEn; // RULE4

    swc_osc_tick #(
        .OSC_HZ(swc_pkg::OSC_HZ),
        .CORE_HZ(swc_pkg::CORE_HZ)
    ) u_osc (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .run(oscRun),
        .tick(oscTick)
    );

    // ********************
    // reset sources and wake conditions
    // ********************

    // simultaneous-high detection on group A, option and enable gated
    assign simulHigh = SIMUL_RESET_EN && cur.ctrl[swc_pkg::CTRL_DET_A] && (&keyGroupA); // RULE8
    // watchdog expiry only when built in
    assign wdtExpire = WATCHDOG_EN && oscTick && (cur.wdtCnt == WDT_PERIOD - 16'h0001); // RULE11
    // pin is low-active; the synchronizer idles high like the pull-up
    assign rstSource = !cur.syncRst2 || simulHigh || wdtExpire; // RULE14 RULE12
    // key wake uses permissions latched at entry
    assign keyWake = (cur.permA && (|keyGroupA)) || (cur.permB && (|keyGroupB)); // RULE5 RULE6

    // apb phases
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && ce && mapped(paddr) && pstrb[0];

    // ********************
    // next state
    // ********************
    always_comb begin
        next_cur = cur;
        irqSet = '0;
        irqClr = '0;
        next_cur.wakePulse = 1'b0;
        next_cur.relReq = 1'b0;
        next_cur.instrTick = 1'b0;

        // two-stage synchronizer for the reset pin
        next_cur.syncRst1 = resetInputPin_n; // RULE14
        next_cur.syncRst2 = cur.syncRst1;

        // instruction cycle of eight oscillator periods
        if (oscTick) begin
            next_cur.instrDiv = cur.instrDiv + 3'h1;
            next_cur.instrTick = (cur.instrDiv == INSTR_LAST) && cur.fetchEn && !holdReq && !rstSource; // RULE10
        end

        // free-running release-request timer, stops with the oscillator
        if (oscTick) begin
            if (cur.frtCnt == FRT_PERIOD - 16'h0001) begin
                next_cur.frtCnt = '0;
                next_cur.relReq = 1'b1; // RULE3
                irqSet[swc_pkg::IRQ_REL_REQ] = 1'b1;
            end else begin
                next_cur.frtCnt = cur.frtCnt + 16'h0001;
            end
        end

        // watchdog counts only while the program runs
        if (!WATCHDOG_EN || wdtKick || cur.mode != swc_pkg::SWC_RUN) begin
            next_cur.wdtCnt = '0;
        end else if (oscTick) begin
            next_cur.wdtCnt = wdtExpire ? '0 : cur.wdtCnt + 16'h0001; // RULE11
        end

        // mode sequencing
        if (rstSource) begin
            next_cur.mode = swc_pkg::SWC_RESET;
            next_cur.holdCnt = '0;
            next_cur.sysReset = 1'b1; // RULE14 RULE2 RULE5
            if (cur.mode != swc_pkg::SWC_RESET) begin
                irqSet[swc_pkg::IRQ_SYS_RST] = 1'b1;
            end
        end else begin
            case (cur.mode)
                swc_pkg::SWC_RESET: begin
                    if (cur.holdCnt == HOLD_LAST) begin
                        next_cur.mode = swc_pkg::SWC_RUN; // RULE14
                        next_cur.sysReset = 1'b0;
                    end else begin
                        next_cur.holdCnt = cur.holdCnt + 12'h001;
                    end
                end
                swc_pkg::SWC_RUN: begin
                    if (holdReq) begin
                        next_cur.mode = swc_pkg::SWC_HOLD;
                        next_cur.permA = cur.ctrl[swc_pkg::CTRL_WAKE_A]; // RULE6
                        next_cur.permB = cur.ctrl[swc_pkg::CTRL_WAKE_B]; // RULE6
                    end else if (haltReq) begin
                        next_cur.mode = swc_pkg::SWC_HALT; // RULE1
                    end
                end
                swc_pkg::SWC_HALT: begin
                    if (cur.relReq) begin
                        next_cur.mode = swc_pkg::SWC_RUN; // RULE2
                        next_cur.wakePulse = 1'b1; // RULE13
                        irqSet[swc_pkg::IRQ_HALT_WAKE] = 1'b1;
                    end
                end
                swc_pkg::SWC_HOLD: begin
                    if (keyWake) begin
                        next_cur.mode = swc_pkg::SWC_RUN; // RULE5
                        next_cur.wakePulse = 1'b1; // RULE13
                        irqSet[swc_pkg::IRQ_HOLD_WAKE] = 1'b1;
                    end
                end
                default: begin
                    next_cur.mode = swc_pkg::SWC_RESET;
                    next_cur.sysReset = 1'b1;
                end
            endcase
        end

        // outputs follow the next mode so they change with it
        next_cur.fetchEn = (next_cur.mode == swc_pkg::SWC_RUN); // RULE1 RULE13
        next_cur.oscOutEn = (next_cur.mode != swc_pkg::SWC_HOLD); // RULE7 RULE4

        // register writes
        if (apbWrite && regHit(paddr, swc_pkg::OFS_CTRL)) begin
            next_cur.ctrl = pwdata[4:0];
        end
        if (apbWrite && regHit(paddr, swc_pkg::OFS_IRQ_MASK)) begin
            next_cur.irqMask = pwdata[swc_pkg::IRQ_W-1:0];
        end
        if (apbWrite && regHit(paddr, swc_pkg::OFS_IRQ_STAT)) begin
            irqClr = pwdata[swc_pkg::IRQ_W-1:0];
        end

        // system reset forces pull-downs and detection on, permissions off
        if (next_cur.sysReset) begin
            next_cur.ctrl[swc_pkg::CTRL_PD_A] = 1'b1; // RULE9
            next_cur.ctrl[swc_pkg::CTRL_PD_B] = 1'b1; // RULE9
            next_cur.ctrl[swc_pkg::CTRL_DET_A] = 1'b1; // RULE9
            next_cur.permA = 1'b0;
            next_cur.permB = 1'b0;
        end

        // sticky flags: a new event wins over a clear in the same cycle
        next_cur.irqStat = (cur.irqStat & ~irqClr) | irqSet;

        // read data captured in the setup phase
        if (apbSetup) begin
            next_cur.prdata = readMux(paddr, cur);
        end
    end

    // ********************
    // state register
    // ********************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur.mode <= swc_pkg::SWC_RESET;
            cur.syncRst1 <= 1'b1;
            cur.syncRst2 <= 1'b1;
            cur.holdCnt <= '0;
            cur.instrDiv <= '0;
            cur.instrTick <= 1'b0;
            cur.frtCnt <= '0;
            cur.relReq <= 1'b0;
            cur.wdtCnt <= '0;
            cur.permA <= 1'b0;
            cur.permB <= 1'b0;
            cur.ctrl <= swc_pkg::CTRL_RESET; // RULE9
            cur.irqStat <= swc_pkg::IRQ_STAT_RESET;
            cur.irqMask <= swc_pkg::IRQ_MASK_RESET;
            cur.prdata <= 32'h0000_0000;
            cur.fetchEn <= 1'b0;
            cur.oscOutEn <= 1'b1;
            cur.sysReset <= 1'b1;
            cur.wakePulse <= 1'b0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    // ********************
    // outputs
    // ********************

    // apb answers at once unless frozen
    assign pready = ce;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = cur.prdata;

    // core side
    assign fetchEnable = cur.fetchEn;
    assign instrTick = cur.instrTick;
    assign sysReset = cur.sysReset;
    assign wakeResume = cur.wakePulse;

    // pins
    assign oscOutPinEnable = cur.oscOutEn; // RULE7
    assign pullDownA = cur.ctrl[swc_pkg::CTRL_PD_A];
    assign pullDownB = cur.ctrl[swc_pkg::CTRL_PD_B];

    // level interrupt from unmasked sticky flags
    assign irq = |(cur.irqStat & cur.irqMask);

endmodule

`default_nettype wire

// ### test/swc_key_model.sv
// key matrix switches and external reset circuit model
`default_nettype none

module swc_key_model (
    // clock
    input wire logic core_clk,
    // commands from the bench
    input wire logic [3:0] pressA,
    input wire logic [3:0] pressB,
    input wire logic resetLow,
    // pull-down enables from the device
    input wire logic pullDownA,
    input wire logic pullDownB,
    // pins
    output logic resetInputPin_n,
    output logic [3:0] keyGroupA,
    output logic [3:0] keyGroupB
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] drift = 4'h5;

    // open keys sit at the pull-down level, else drift, never all high
    always @(posedge core_clk) begin
        drift <= ~drift;
        keyGroupA <= pressA | (pullDownA ? 4'h0 : drift);
        keyGroupB <= pressB | (pullDownB ? 4'h0 : drift);
        resetInputPin_n <= ~resetLow;
    end
endmodule

`default_nettype wire

// ### test/standby_wake_control_monitor.sv
// checker of the standby and wake controller port behaviour
`default_nettype none

module swc_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // core side
    input wire logic haltReq,
    input wire logic holdReq,
    input wire logic fetchEnable,
    input wire logic instrTick,
    input wire logic sysReset,
    input wire logic wakeResume,
    // pins and interrupt
    input wire logic [3:0] keyGroupA,
    input wire logic [3:0] keyGroupB,
    input wire logic oscOutPinEnable,
    input wire logic pullDownA,
    input wire logic pullDownB,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned highCnt;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // length of the current system reset stretch
    always_ff @(posedge core_clk) begin
        if (rst || !sysReset) begin
            highCnt <= 0;
        end else begin
            highCnt <= highCnt + 1;
        end
    end

    // ********************
    // assertions
    // ********************
    halt_stops_fetch_a: assert property (haltReq && !holdReq && fetchEnable && !sysReset
        |=> !fetchEnable && oscOutPinEnable) else $error("halt entry wrong");
    hold_drive_off_a: assert property (holdReq && fetchEnable && !sysReset
        |=> !oscOutPinEnable && !fetchEnable) else $error("hold entry wrong");
    osc_stop_quiet_a: assert property (!oscOutPinEnable |-> !fetchEnable && !instrTick)
        else $error("activity with oscillator stopped");
    key_wake_a: assert property ($rose(oscOutPinEnable) && !sysReset |-> (|$past(keyGroupA))
        || (|$past(keyGroupB)) || (|$past(keyGroupA, 2)) || (|$past(keyGroupB, 2)))
        else $error("hold left without key");
    resume_ok_a: assert property (wakeResume |-> fetchEnable && oscOutPinEnable && !sysReset)
        else $error("resume without fetch");
    simul_reset_a: assert property ((&keyGroupA) [*3] |-> sysReset)
        else $error("all keys high gave no reset");
    reset_pulls_a: assert property (sysReset ##1 sysReset |-> pullDownA && pullDownB)
        else $error("pull-downs off in reset");
    reset_nofetch_a: assert property (sysReset |-> !fetchEnable)
        else $error("fetch during reset");
    stretch_len_a: assert property ($fell(sysReset) |-> highCnt >= swc_pkg::RST_HOLD_CYCLES - 1)
        else $error("reset stretch short");
    tick_gap_a: assert property (instrTick |=> !instrTick [*8])
        else $error("instruction ticks too close");

    // main scenarios
    halt_wake_c: cover property (!fetchEnable && oscOutPinEnable ##1 wakeResume);
    hold_wake_c: cover property ($rose(oscOutPinEnable) && !sysReset);
    simul_c: cover property (&keyGroupA ##1 sysReset);
    irq_c: cover property ($rose(irq));
endmodule

bind standby_wake_control swc_monitor i_mon (.core_clk(core_clk), .rst(rst), .haltReq(haltReq),
    .holdReq(holdReq), .fetchEnable(fetchEnable), .instrTick(instrTick), .sysReset(sysReset),
    .wakeResume(wakeResume), .keyGroupA(keyGroupA), .keyGroupB(keyGroupB),
    .oscOutPinEnable(oscOutPinEnable), .pullDownA(pullDownA), .pullDownB(pullDownB), .irq(irq));

`default_nettype wire

// ### test/standby_wake_control_test.sv
// self-checking testbench of the standby and wake controller
`default_nettype none

module standby_wake_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic haltReq = 1'b0;
    logic holdReq = 1'b0;
    logic wdtKick = 1'b0;
    logic [3:0] pressA = 4'h0;
    logic [3:0] pressB = 4'h0;
    logic resetLow = 1'b0;
    logic ce = 1'b1;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, fetchEnable, instrTick, sysReset, wakeResume, oscOutPinEnable, e;
    logic pullDownA, pullDownB, irq, resetInputPin_n;
    logic [3:0] keyGroupA, keyGroupB;
    bit kickOn = 1'b1;
    int mismatches = 0;
    int numChecks = 0;
    int n;

    standby_wake_control #(.FRT_PERIOD(16'h0010), .WDT_PERIOD(16'h0020)) i_dut (
        .core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .haltReq(haltReq), .holdReq(holdReq), .wdtKick(wdtKick), .fetchEnable(fetchEnable),
        .instrTick(instrTick), .sysReset(sysReset), .wakeResume(wakeResume),
        .resetInputPin_n(resetInputPin_n), .keyGroupA(keyGroupA), .keyGroupB(keyGroupB),
        .oscOutPinEnable(oscOutPinEnable), .pullDownA(pullDownA), .pullDownB(pullDownB), .irq(irq));
    swc_key_model i_keys (.core_clk(core_clk), .pressA(pressA), .pressB(pressB), .resetLow(resetLow),
        .pullDownA(pullDownA), .pullDownB(pullDownB), .resetInputPin_n(resetInputPin_n),
        .keyGroupA(keyGroupA), .keyGroupB(keyGroupB));

    // ********************
    // helpers
    // ********************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        numChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // one apb transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0);
        check(q & m, x, s);
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return fetchEnable;
            1: return sysReset;
            2: return wakeResume;
            default: return instrTick;
        endcase
    endfunction

    // count edges until the chosen output reaches lvl
    task automatic waitFor(input int sel, input logic lvl, input int maxc);
        n = 0;
        while (pick(sel) !== lvl && n < maxc) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= maxc) begin
            mismatches++;
            $display("[ERR] %0t wait limit on output %0d", $time, sel);
        end
    endtask

    // one-cycle standby request from the core
    task automatic go(input logic hold);
        if (hold) holdReq <= 1'b1;
        else haltReq <= 1'b1;
        @(posedge core_clk);
        holdReq <= 1'b0;
        haltReq <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // clock, watchdog kicks and run limit
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        forever begin
            repeat (1000) @(posedge core_clk);
            if (kickOn) wdtKick <= 1'b1;
            @(posedge core_clk);
            wdtKick <= 1'b0;
        end
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        $display("[ERR] %0t run did not finish", $time);
        summarize();
    end

    // ********************
    // tests
    // ********************
    initial begin
        repeat (10) @(posedge core_clk);
        check(32'({pullDownA, pullDownB, sysReset}), 32'h7, "reset pins");
        rst <= 1'b0;
        @(posedge core_clk);
        rdc(swc_pkg::OFS_CTRL, 32'h1F, 32'h1C, "ctrl reset");
        rdc(swc_pkg::OFS_IRQ_MASK, 32'hF, 32'h0, "mask reset");
        apb(1'b0, 12'h010, 32'h0);
        check(32'({e, |q}), 32'h2, "unmapped");
        waitFor(0, 1'b1, 3000);
        check(32'(n >= 1740), 32'h1, "reset stretch");
        rdc(swc_pkg::OFS_STATUS, 32'h1F, 32'h19, "run status");
        $display("test reset finished");
        wr(swc_pkg::OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 2; i++) begin
            go(1'b0);
            check(32'({irq, fetchEnable, oscOutPinEnable}), 32'h1, "halt entry");
            rdc(swc_pkg::OFS_STATUS, 32'h3, 32'h2, "halt mode");
            waitFor(2, 1'b1, 4000);
            check(32'({fetchEnable, sysReset}), 32'h2, "halt wake");
            if (i == 1) check(32'(n > 3300 && n < 3530), 32'h1, "release period");
            repeat (2) @(posedge core_clk);
            check(32'(irq), 32'h1, "halt irq");
            rdc(swc_pkg::OFS_IRQ_STAT, 32'h5, 32'h5, "halt events");
            wr(swc_pkg::OFS_IRQ_STAT, 32'h5);
        end
        $display("test halt finished");
        go(1'b1);
        check(32'({fetchEnable, oscOutPinEnable}), 32'h0, "hold entry");
        rdc(swc_pkg::OFS_STATUS, 32'h13, 32'h3, "hold status");
        wr(swc_pkg::OFS_IRQ_STAT, 32'hF);
        pressB <= 4'h1;
        repeat (4000) @(posedge core_clk);
        wr(swc_pkg::OFS_CTRL, 32'h1D);
        pressA <= 4'h1;
        repeat (20) @(posedge core_clk);
        check(32'(fetchEnable), 32'h0, "no permission");
        rdc(swc_pkg::OFS_IRQ_STAT, 32'h4, 32'h0, "timer frozen");
        pressA <= 4'h0;
        pressB <= 4'h0;
        resetLow <= 1'b1;
        waitFor(1, 1'b1, 20);
        resetLow <= 1'b0;
        waitFor(0, 1'b1, 3000);
        check(32'(n >= 1750), 32'h1, "pin stretch");
        $display("test hold refused finished");
        for (int g = 0; g < 2; g++) begin
            wr(swc_pkg::OFS_IRQ_STAT, 32'hF);
            wr(swc_pkg::OFS_CTRL, g ? 32'h1E : 32'h1D);
            go(1'b1);
            repeat (5) @(posedge core_clk);
            if (g) pressB <= 4'h8;
            else pressA <= 4'h2;
            waitFor(2, 1'b1, 12);
            check(32'({fetchEnable, oscOutPinEnable, sysReset}), 32'h6, "hold wake");
            pressA <= 4'h0;
            pressB <= 4'h0;
            rdc(swc_pkg::OFS_IRQ_STAT, 32'h2, 32'h2, "hold event");
        end
        $display("test hold wake finished");
        wr(swc_pkg::OFS_CTRL, 32'h1C);
        pressA <= 4'hF;
        waitFor(1, 1'b1, 10);
        pressA <= 4'h0;
        waitFor(0, 1'b1, 3000);
        rdc(swc_pkg::OFS_IRQ_STAT, 32'h8, 32'h8, "reset event");
        waitFor(3, 1'b1, 2000);
        @(posedge core_clk);
        waitFor(3, 1'b1, 2000);
        check(32'(n > 1745 && n < 1765), 32'h1, "instruction cycle");
        $display("test keys and ticks finished");
        kickOn = 1'b0;
        waitFor(1, 1'b1, 9000);
        check(32'(n > 5900), 32'h1, "watchdog span");
        kickOn = 1'b1;
        waitFor(0, 1'b1, 3000);
        $display("test watchdog finished");
        go(1'b0);
        ce <= 1'b0;
        repeat (4000) @(posedge core_clk);
        check(32'({pready, fetchEnable}), 32'h0, "frozen halt");
        ce <= 1'b1;
        waitFor(2, 1'b1, 4000);
        $display("test clock enable finished");
        summarize();
    end
endmodule

`default_nettype wire
